// ---- hdl/mrdt_mode_trim.sv ----
// Mode register programming and output driver trim control
// Notes on behaviour
// - Operations are a first command then a second command on the next clock.
// - Mode set is accepted only as second command after read-activate, banks idle.
// - Mode set after read-activate cancels that read.
// - Register contents load from address 0-13 and bank 0.
// - Bank 1:0 = 00 regular, 01 extended, bank 1 high reserved.
// - Registers hold until rewritten; controller must program them first.
// - Burst length code 001 gives two, 010 gives four; others reserved.
// - Address bit 3 picks sequential or interleaved burst order.
// - Sequential order increments, wrapping in one or two low bits.
// - Interleaved order flips the low lower-address bits.
// - Latency codes 011, 100, 101 mean 3, 4, 5 clocks.
// - Extended bit 0 low enables the DLL.
// - Extended bits 6,1 pick normal, strong, weak or full drive.
// - Trim only with full drive; chosen strength is the start level. Code gates only adjust on full drive and starts both levels at TRIM_MID.
// - Extended bits 9-7 select exit, drive high, drive low, adjust, default.
// - Drive high sets data and strobe high, complement low; drive low opposite.
// - One code applies to every data line equally.
// - Code decode raises or lowers pull-up and pull-down per table.
// - Each trim limited to 16 steps; further codes ignored.
`timescale 1ns/10ps
module mrdt_mode_trim (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Command pins
  input wire mrdt_pkg::mrdt_cmd_e cmd,
  input wire logic banks_idle,
  input wire logic [mrdt_pkg::ADDR_W-1:0] addr,
  input wire logic [mrdt_pkg::BANK_W-1:0] bank,
  // Write data beats, one per data line
  input wire logic [mrdt_pkg::DQ_W-1:0] dq_in,
  // Data and strobe pins
  output logic [mrdt_pkg::DQ_W-1:0] dq_out,
  output logic [mrdt_pkg::DQ_W-1:0] dq_oe,
  output logic dqs_out,
  output logic dqs_n_out,
  output logic dqs_oe,
  output logic dqs_n_oe,
  // Decoded mode state
  output logic read_cancel,
  output logic [2:0] burst_len,
  output logic burst_interleave,
  output logic [2:0] access_latency,
  output logic [2:0] write_latency,
  output logic test_mode,
  output logic dll_enable,
  output logic [1:0] drive_strength,
  output logic dqs_n_enable,
  output logic [mrdt_pkg::TRIM_W-1:0] pullup_level,
  output logic [mrdt_pkg::TRIM_W-1:0] pulldown_level,
  // Burst address query
  input wire logic [1:0] beat_start,
  input wire logic [1:0] beat_index,
  output logic [1:0] beat_addr
);
  typedef enum logic [1:0] {ST_IDLE, ST_FIRST_RD, ST_FIRST_WR} mrdt_seq_e;
  typedef enum logic [1:0] {TR_OFF, TR_DRIVE_HI, TR_DRIVE_LO, TR_ADJUST} mrdt_trim_e;

  mrdt_seq_e seq_q;
  mrdt_trim_e trim_q;
  logic [mrdt_pkg::MODE_W-1:0] regular_mode_register_q;
  logic [mrdt_pkg::MODE_W-1:0] extended_mode_register_q;
  logic [mrdt_pkg::MODE_W-1:0] mode_word;
  logic mode_set_cmd;
  logic regular_wr;
  logic extended_wr;
  logic [2:0] trim_op;
  logic [2:0] lat_cnt_q;
  logic lat_run_q;
  logic [1:0] beat_cnt_q;
  logic beat_run_q;
  logic [3:0] code_q;
  logic code_done_q;
  logic pu_up;
  logic pu_dn;
  logic pd_up;
  logic pd_dn;
  logic trim_default;
  logic [1:0] ext_strength;
  logic trim_drive;
  logic trim_high;

  // Second command is only meaningful right after a first command
  always_ff @(posedge core_clk) begin
    if (reset) begin
      seq_q <= ST_IDLE;
    end else begin
      case (cmd)
        mrdt_pkg::CMD_READ_ACT: begin
          seq_q <= ST_FIRST_RD;
        end
        mrdt_pkg::CMD_WRA: begin
          seq_q <= ST_FIRST_WR;
        end
        default: begin
          seq_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign mode_set_cmd = (seq_q == ST_FIRST_RD) && (cmd == mrdt_pkg::CMD_MODE_SET)
                        && banks_idle;
  // Select bits 1 and 2 carry no content; bank 0 tops the stored word
  assign mode_word = {bank[0], addr};
  assign regular_wr = mode_set_cmd && (bank[1:0] == mrdt_pkg::SEL_REGULAR);
  assign extended_wr = mode_set_cmd && (bank[1:0] == mrdt_pkg::SEL_EXTENDED);
  assign trim_op = addr[mrdt_pkg::TRIM_LSB +: 3];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      read_cancel <= 1'b0;
    end else begin
      read_cancel <= mode_set_cmd;
    end
  end

  // Reset to zero only for determinism; contents are undefined to the controller
  always_ff @(posedge core_clk) begin
    if (reset) begin
      regular_mode_register_q <= mrdt_pkg::MODE_RESET;
    end else if (regular_wr) begin
      regular_mode_register_q <= mode_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      extended_mode_register_q <= mrdt_pkg::MODE_RESET;
    end else if (extended_wr) begin
      extended_mode_register_q <= mode_word;
    end
  end

  // Reserved codes decode as zero so a missed setup is visible
  always_comb begin
    case (regular_mode_register_q[mrdt_pkg::BURST_LEN_LSB +: 3])
      mrdt_pkg::BURST_CODE_2: begin
        burst_len = 3'h2;
      end
      mrdt_pkg::BURST_CODE_4: begin
        burst_len = 3'h4;
      end
      default: begin
        burst_len = 3'h0;
      end
    endcase
  end

  always_comb begin
    case (regular_mode_register_q[mrdt_pkg::LATENCY_LSB +: 3])
      mrdt_pkg::LATENCY_CODE_3: begin
        access_latency = 3'h3;
      end
      mrdt_pkg::LATENCY_CODE_4: begin
        access_latency = 3'h4;
      end
      mrdt_pkg::LATENCY_CODE_5: begin
        access_latency = 3'h5;
      end
      default: begin
        access_latency = 3'h0;
      end
    endcase
  end

  // Write data is due one clock ahead of read data
  always_comb begin
    if (access_latency == 3'h0) begin
      write_latency = 3'h0;
    end else begin
      write_latency = access_latency - 3'h1;
    end
  end

  assign burst_interleave = regular_mode_register_q[mrdt_pkg::BURST_ORDER_POS];
  assign test_mode = regular_mode_register_q[mrdt_pkg::TEST_BIT_POS];
  assign dll_enable = ~extended_mode_register_q[mrdt_pkg::DLL_SWITCH_POS];
  assign drive_strength = {extended_mode_register_q[mrdt_pkg::STRENGTH_HI_POS],
                           extended_mode_register_q[mrdt_pkg::STRENGTH_LO_POS]};
  assign dqs_n_enable = extended_mode_register_q[mrdt_pkg::DQSB_POS];

  mrdt_burst_addr u_burst_addr (
    .start_addr(beat_start),
    .interleave(burst_interleave),
    .len_four(burst_len == 3'h4),
    .beat(beat_index),
    .beat_addr(beat_addr)
  );

  // Trim mode follows each extended write; strength field only takes effect with adjust
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trim_q <= TR_OFF;
    end else if (extended_wr) begin
      case (trim_op)
        mrdt_pkg::TRIM_DRIVE_HI: begin
          trim_q <= TR_DRIVE_HI;
        end
        mrdt_pkg::TRIM_DRIVE_LO: begin
          trim_q <= TR_DRIVE_LO;
        end
        mrdt_pkg::TRIM_ADJUST: begin
          // Adjust below full strength is ignored rather than guessed at
          if (ext_strength == mrdt_pkg::STRENGTH_FULL) begin
            trim_q <= TR_ADJUST;
          end else begin
            trim_q <= TR_OFF;
          end
        end
        default: begin
          trim_q <= TR_OFF;
        end
      endcase
    end else if (trim_q == TR_ADJUST && code_done_q) begin
      trim_q <= TR_OFF;
    end
  end

  assign ext_strength = {addr[mrdt_pkg::STRENGTH_HI_POS], addr[mrdt_pkg::STRENGTH_LO_POS]};

  assign trim_default = extended_wr && (trim_op == mrdt_pkg::TRIM_DEFAULT);

  // Adjust code arrives write latency clocks after the adjust command
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lat_run_q <= 1'b0;
      lat_cnt_q <= 3'h0;
    end else if (extended_wr && trim_op == mrdt_pkg::TRIM_ADJUST) begin
      lat_run_q <= 1'b1;
      lat_cnt_q <= write_latency;
    end else if (lat_run_q) begin
      lat_cnt_q <= lat_cnt_q - 3'h1;
      if (lat_cnt_q <= 3'h1) begin
        lat_run_q <= 1'b0;
      end
    end
  end

  // Four beats in fixed order, independent of burst order; bit 0 line is sampled
  always_ff @(posedge core_clk) begin
    if (reset) begin
      beat_run_q <= 1'b0;
      beat_cnt_q <= 2'h0;
      code_q <= 4'h0;
      code_done_q <= 1'b0;
    end else begin
      code_done_q <= 1'b0;
      if (lat_run_q && lat_cnt_q <= 3'h1) begin
        beat_run_q <= 1'b1;
        beat_cnt_q <= 2'h0;
      end else if (beat_run_q) begin
        code_q <= {code_q[2:0], dq_in[0]};
        beat_cnt_q <= beat_cnt_q + 2'h1;
        if (beat_cnt_q == 2'h3) begin
          beat_run_q <= 1'b0;
          code_done_q <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    pu_up = 1'b0;
    pu_dn = 1'b0;
    pd_up = 1'b0;
    pd_dn = 1'b0;
    if (code_done_q && trim_q == TR_ADJUST) begin
      case (code_q)
        mrdt_pkg::CODE_PU_UP: pu_up = 1'b1;
        mrdt_pkg::CODE_PU_DN: pu_dn = 1'b1;
        mrdt_pkg::CODE_PD_UP: pd_up = 1'b1;
        mrdt_pkg::CODE_PD_DN: pd_dn = 1'b1;
        mrdt_pkg::CODE_BOTH_UP: begin
          pu_up = 1'b1;
          pd_up = 1'b1;
        end
        mrdt_pkg::CODE_PUDN_PDUP: begin
          pu_dn = 1'b1;
          pd_up = 1'b1;
        end
        mrdt_pkg::CODE_PUUP_PDDN: begin
          pu_up = 1'b1;
          pd_dn = 1'b1;
        end
        mrdt_pkg::CODE_BOTH_DN: begin
          pu_dn = 1'b1;
          pd_dn = 1'b1;
        end
        default: pu_up = 1'b0;
      endcase
    end
  end

  // Shared levels keep every data line at the same strength
  mrdt_trim_step u_pullup (
    .core_clk(core_clk),
    .reset(reset),
    .load_default(trim_default),
    .step_up(pu_up),
    .step_down(pu_dn),
    .level_q(pullup_level),
    .steps_q()
  );

  mrdt_trim_step u_pulldown (
    .core_clk(core_clk),
    .reset(reset),
    .load_default(trim_default),
    .step_up(pd_up),
    .step_down(pd_dn),
    .level_q(pulldown_level),
    .steps_q()
  );

  // Drive mode pin levels
  assign trim_drive = (trim_q == TR_DRIVE_HI) || (trim_q == TR_DRIVE_LO);
  assign trim_high = (trim_q == TR_DRIVE_HI);

  for (genvar i = 0; i < mrdt_pkg::DQ_W; i++) begin : g_dq_pin
    always_ff @(posedge core_clk) begin
      if (reset) begin
        dq_out[i] <= 1'b0;
        dq_oe[i] <= 1'b0;
      end else begin
        dq_out[i] <= trim_high;
        dq_oe[i] <= trim_drive;
      end
    end
  end

  // Complement strobe drives only when enabled, else the pin would fight the board
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dqs_out <= 1'b0;
      dqs_n_out <= 1'b0;
      dqs_oe <= 1'b0;
      dqs_n_oe <= 1'b0;
    end else begin
      dqs_out <= trim_high;
      dqs_n_out <= (trim_q == TR_DRIVE_LO);
      dqs_oe <= trim_drive;
      dqs_n_oe <= trim_drive && dqs_n_enable;
    end
  end
endmodule

// ---- hdl/mrdt_pkg.sv ----
// Constants for the mode register and driver trim block
package mrdt_pkg;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int DQ_W = 16;
  localparam int MODE_W = 15;
  localparam int TRIM_W = 5;
  // Register select on bank inputs
  localparam logic [1:0] SEL_REGULAR = 2'h0;
  localparam logic [1:0] SEL_EXTENDED = 2'h1;
  // Regular register fields
  localparam int BURST_LEN_LSB = 0;
  localparam int BURST_ORDER_POS = 3;
  localparam int LATENCY_LSB = 4;
  localparam int TEST_BIT_POS = 7;
  localparam logic [2:0] BURST_CODE_2 = 3'h1;
  localparam logic [2:0] BURST_CODE_4 = 3'h2;
  localparam logic [2:0] LATENCY_CODE_3 = 3'h3;
  localparam logic [2:0] LATENCY_CODE_4 = 3'h4;
  localparam logic [2:0] LATENCY_CODE_5 = 3'h5;
  // Extended register fields
  localparam int DLL_SWITCH_POS = 0;
  localparam int STRENGTH_LO_POS = 1;
  localparam int STRENGTH_HI_POS = 6;
  localparam int TRIM_LSB = 7;
  localparam int DQSB_POS = 10;
  localparam logic [1:0] STRENGTH_NORMAL = 2'h0;
  localparam logic [1:0] STRENGTH_STRONG = 2'h1;
  localparam logic [1:0] STRENGTH_WEAK = 2'h2;
  localparam logic [1:0] STRENGTH_FULL = 2'h3;
  localparam logic [2:0] TRIM_EXIT = 3'h0;
  localparam logic [2:0] TRIM_DRIVE_HI = 3'h1;
  localparam logic [2:0] TRIM_DRIVE_LO = 3'h2;
  localparam logic [2:0] TRIM_ADJUST = 3'h4;
  localparam logic [2:0] TRIM_DEFAULT = 3'h7;
  // Trim code decode (beat 0 in bit 3)
  localparam logic [3:0] CODE_NOP = 4'h0;
  localparam logic [3:0] CODE_PU_UP = 4'h1;
  localparam logic [3:0] CODE_PU_DN = 4'h2;
  localparam logic [3:0] CODE_PD_UP = 4'h4;
  localparam logic [3:0] CODE_PD_DN = 4'h8;
  localparam logic [3:0] CODE_BOTH_UP = 4'h5;
  localparam logic [3:0] CODE_PUDN_PDUP = 4'h6;
  localparam logic [3:0] CODE_PUUP_PDDN = 4'h9;
  localparam logic [3:0] CODE_BOTH_DN = 4'hA;
  localparam logic [TRIM_W-1:0] TRIM_MID = 5'h08;
  localparam logic [TRIM_W-1:0] TRIM_MAX_STEP = 5'h10;
  localparam logic [TRIM_W-1:0] TRIM_ZERO = 5'h00;
  localparam logic [MODE_W-1:0] MODE_RESET = 15'h0000;
  // Command codes
  typedef enum logic [2:0] {
    CMD_NOP, CMD_READ_ACT, CMD_WRA, CMD_ADDR_LATCH, CMD_MODE_SET, CMD_REF
  } mrdt_cmd_e;
endpackage

// ---- hdl/mrdt_burst_addr.sv ----
// Lower address sequencing for one burst beat
`timescale 1ns/10ps
module mrdt_burst_addr (
  // Start and setup
  input wire logic [1:0] start_addr,
  input wire logic interleave,
  input wire logic len_four,
  input wire logic [1:0] beat,
  // Result
  output logic [1:0] beat_addr
);
  logic [1:0] seq_sum;
  always_comb begin
    seq_sum = start_addr + beat;
    if (interleave) begin
      beat_addr = len_four ? (start_addr ^ beat) : {start_addr[1], start_addr[0] ^ beat[0]};
    end else if (len_four) begin
      beat_addr = seq_sum;
    end else begin
      beat_addr = {start_addr[1], seq_sum[0]};
    end
  end
endmodule

// ---- hdl/mrdt_trim_step.sv ----
// One step-limited trim strength counter
`timescale 1ns/10ps
module mrdt_trim_step (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic load_default,
  input wire logic step_up,
  input wire logic step_down,
  // State
  output logic [mrdt_pkg::TRIM_W-1:0] level_q,
  output logic [mrdt_pkg::TRIM_W-1:0] steps_q
);
  always_ff @(posedge core_clk) begin
    if (reset || load_default) begin
      level_q <= mrdt_pkg::TRIM_MID;
      steps_q <= mrdt_pkg::TRIM_ZERO;
    end else if ((step_up || step_down) && steps_q != mrdt_pkg::TRIM_MAX_STEP) begin
      steps_q <= steps_q + 5'h01;
      level_q <= step_up ? level_q + 5'h01 : level_q - 5'h01;
    end
  end
endmodule

// ---- verification/mrdt_mode_trim_props.sv ----
// Port checks for the mode register and driver trim block
`timescale 1ns/10ps
module mrdt_mode_trim_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Command pins
  input wire mrdt_pkg::mrdt_cmd_e cmd,
  input wire logic banks_idle,
  input wire logic [13:0] addr,
  input wire logic [2:0] bank,
  // Outputs
  input wire logic [15:0] dq_out,
  input wire logic dqs_out,
  input wire logic dqs_n_out,
  input wire logic read_cancel,
  input wire logic [2:0] burst_len,
  input wire logic burst_interleave,
  input wire logic [2:0] access_latency,
  input wire logic [2:0] write_latency,
  input wire logic dll_enable,
  input wire logic [1:0] drive_strength,
  input wire logic [1:0] beat_start,
  input wire logic [1:0] beat_index,
  input wire logic [1:0] beat_addr
);
  mrdt_pkg::mrdt_cmd_e prev_q;
  logic [13:0] addr_q;
  logic acc;
  // Free running so the pair history is valid right after reset
  always_ff @(posedge core_clk) begin
    prev_q <= cmd;
    addr_q <= addr;
  end
  assign acc = cmd == mrdt_pkg::CMD_MODE_SET && prev_q == mrdt_pkg::CMD_READ_ACT
               && banks_idle && !bank[1];
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_set_cancels_read: assert property (acc |=> read_cancel) else $error("no cancel");
  a_refused_holds: assert property (cmd == mrdt_pkg::CMD_MODE_SET && !acc
    |=> $stable(burst_len) && $stable(drive_strength)) else $error("refused set took effect");
  a_regs_hold: assert property (cmd != mrdt_pkg::CMD_MODE_SET
    |=> $stable(access_latency) && $stable(dll_enable)) else $error("register drifted");
  a_burst_len: assert property (acc && !bank[0] && addr[2:0] inside {3'h1, 3'h2}
    |=> burst_len == {addr_q[1:0], 1'b0}) else $error("burst length decode");
  a_latency_codes: assert property (acc && !bank[0] && addr[6:4] inside {3'h3, 3'h4, 3'h5}
    |=> access_latency == addr_q[6:4] && write_latency == addr_q[6:4] - 3'h1) else $error("latency");
  a_strength_dll: assert property (acc && bank[0]
    |=> drive_strength == {addr_q[6], addr_q[1]} && dll_enable == !addr_q[0]) else $error("ext decode");
  a_drive_high: assert property (acc && bank[0] && addr[9:7] == 3'h1
    |-> ##[1:3] dq_out == 16'hFFFF && dqs_out && !dqs_n_out) else $error("drive high levels");
  a_seq_wrap: assert property (burst_len == 3'h4 && !burst_interleave
    |-> beat_addr == 2'(beat_start + beat_index)) else $error("sequential beat address");
  c_ext_write: cover property (acc && bank[0]);
  c_drive_high: cover property (dq_out == 16'hFFFF && dqs_out);
  c_cancel: cover property (read_cancel);
endmodule
bind mrdt_mode_trim mrdt_mode_trim_props u_props (.core_clk, .reset, .cmd, .banks_idle, .addr,
  .bank, .dq_out, .dqs_out, .dqs_n_out, .read_cancel, .burst_len, .burst_interleave,
  .access_latency, .write_latency, .dll_enable, .drive_strength, .beat_start, .beat_index,
  .beat_addr);

// ---- verification/mrdt_ctrl_model.sv ----
// Memory controller model issuing mode set pairs and trim codes
`timescale 1ns/10ps
module mrdt_ctrl_model (
  // Clock
  input wire logic core_clk,
  // Requests
  input wire logic go,
  input wire logic skip_first,
  input wire logic busy_banks,
  input wire logic [16:0] word,
  input wire logic [3:0] code,
  input wire logic [2:0] wr_lat,
  // Pins
  output mrdt_pkg::mrdt_cmd_e cmd,
  output logic banks_idle,
  output logic [13:0] addr,
  output logic [2:0] bank,
  output logic [15:0] dq_in,
  output logic done
);
  initial begin
    cmd = mrdt_pkg::CMD_NOP;
    banks_idle = 1'b1;
    {bank, addr} = 17'h00000;
    dq_in = 16'h0000;
    done = 1'b0;
    forever begin
      @(posedge core_clk);
      if (go) begin
        #1 banks_idle = ~busy_banks;
        cmd = skip_first ? mrdt_pkg::CMD_NOP : mrdt_pkg::CMD_READ_ACT;
        @(posedge core_clk);
        #1 cmd = mrdt_pkg::CMD_MODE_SET;
        {bank, addr} = word;
        @(posedge core_clk);
        #1 cmd = mrdt_pkg::CMD_NOP;
        // Released pins invert so stale values never look valid
        {bank, addr} = ~word;
        banks_idle = 1'b1;
        repeat (wr_lat) @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
          #1 dq_in = {16{code[3 - i]}};
          @(posedge core_clk);
        end
        done = 1'b1;
      end else begin
        #1 done = 1'b0;
        dq_in = ~dq_in;
      end
    end
  end
endmodule

// ---- verification/mrdt_mode_trim_bench.sv ----
// Self-checking bench for the mode register and driver trim block
`timescale 1ns/10ps
module mrdt_mode_trim_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic go = 1'b0;
  logic skip_first = 1'b0;
  logic busy_banks = 1'b0;
  logic [16:0] word = 17'h00000;
  logic [3:0] code = 4'h0;
  logic [2:0] wr_lat_v = 3'h0;
  logic [1:0] beat_start = 2'h0;
  logic [1:0] beat_index = 2'h0;
  logic [15:0] rnd = 16'h8DD7;
  logic done, banks_idle, read_cancel, burst_interleave, test_mode, dll_enable, dqs_n_enable;
  logic dqs_out, dqs_n_out, dqs_oe, dqs_n_oe;
  logic [13:0] addr;
  logic [2:0] bank, burst_len, access_latency, write_latency;
  logic [15:0] dq_in, dq_out, dq_oe;
  logic [1:0] drive_strength, beat_addr;
  logic [4:0] pullup_level, pulldown_level;
  mrdt_pkg::mrdt_cmd_e cmd;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [2:0] sel_q[$];
  logic [39:0] exp_q[$];
  mrdt_ctrl_model u_ctrl (.core_clk, .go, .skip_first, .busy_banks, .word, .code,
    .wr_lat(wr_lat_v),
    .cmd, .banks_idle, .addr, .bank, .dq_in, .done);
  mrdt_mode_trim u_dut (.core_clk, .reset, .cmd, .banks_idle, .addr, .bank, .dq_in, .dq_out,
    .dq_oe, .dqs_out, .dqs_n_out, .dqs_oe, .dqs_n_oe, .read_cancel, .burst_len,
    .burst_interleave, .access_latency, .write_latency, .test_mode, .dll_enable,
    .drive_strength, .dqs_n_enable, .pullup_level, .pulldown_level, .beat_start,
    .beat_index, .beat_addr);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [39:0] obs(input logic [2:0] s);
    case (s)
      3'h0: return 40'({burst_len, burst_interleave, access_latency, write_latency, test_mode});
      3'h1: return 40'({dll_enable, drive_strength, dqs_n_enable});
      3'h2: return 40'({pullup_level, pulldown_level});
      3'h3: return 40'({dq_out, dq_oe, dqs_out, dqs_n_out, dqs_oe, dqs_n_oe});
      3'h4: return 40'({dq_oe, dqs_oe, dqs_n_oe});
      default: return 40'(beat_addr);
    endcase
  endfunction
  // Extended word, full strength and complement strobe on
  function automatic logic [16:0] ext(input logic [2:0] t);
    return {3'h1, 3'h0, 1'b1, t, 1'b1, 4'h0, 2'h2};
  endfunction
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  always @(posedge core_clk) begin
    while (sel_q.size() > 0) check(obs(sel_q.pop_front()), exp_q.pop_front());
  end
  task automatic expect_val(input logic [2:0] s, input logic [39:0] v);
    sel_q.push_back(s);
    exp_q.push_back(v);
    @(posedge core_clk);
    #1;
  endtask
  task automatic mode_set(input logic [16:0] w, input logic [3:0] c);
    int n;
    n = 0;
    word = w;
    code = c;
    go = 1'b1;
    @(posedge core_clk);
    #1 go = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic adj(input logic [3:0] c);
    mode_set(ext(mrdt_pkg::TRIM_ADJUST), c);
    mode_set(ext(mrdt_pkg::TRIM_EXIT), 4'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Sized for roughly five times the expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    logic [2:0] cl;
    logic [4:0] pu;
    logic [4:0] pd;
    repeat (5) @(posedge core_clk);
    #1 reset = 1'b0;
    expect_val(3'h2, 40'h108);
    for (int i = 0; i < 6; i++) begin
      cl = 3'(3 + i % 3);
      mode_set({10'h000, cl, i[0], (i < 3) ? 3'h1 : 3'h2}, 4'h0);
      wr_lat_v = cl - 3'h1;
      expect_val(3'h0, {29'h0, (i < 3) ? 3'h2 : 3'h4, i[0], cl, wr_lat_v, 1'b0});
      for (int k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        beat_start = rnd[1:0];
        beat_index = (i < 3) ? {1'b0, rnd[2]} : rnd[3:2];
        expect_val(3'h5, {38'h0, (i > 2 && !i[0]) ? beat_start + beat_index
          : beat_start ^ beat_index});
      end
    end
    busy_banks = 1'b1;
    mode_set(17'h00031, 4'h0);
    busy_banks = 1'b0;
    skip_first = 1'b1;
    mode_set(17'h00031, 4'h0);
    mode_set(ext(mrdt_pkg::TRIM_EXIT), 4'h0);
    skip_first = 1'b0;
    expect_val(3'h0, {29'h0, 3'h4, 1'b1, 3'h5, 3'h4, 1'b0});
    expect_val(3'h1, 40'h8);
    $display("test regular done");
    for (int s = 0; s < 4; s++) begin
      mode_set({3'h1, 3'h0, s[0], 3'h7, s[1], 4'h0, s[0], s[1]}, 4'h0);
      expect_val(3'h1, {36'h0, ~s[1], s[1:0], s[0]});
      mode_set(ext(mrdt_pkg::TRIM_EXIT), 4'h0);
    end
    mode_set(ext(mrdt_pkg::TRIM_DRIVE_HI), 4'h0);
    expect_val(3'h3, {4'h0, 16'hFFFF, 16'hFFFF, 4'hB});
    mode_set(ext(mrdt_pkg::TRIM_EXIT), 4'h0);
    mode_set(ext(mrdt_pkg::TRIM_DRIVE_LO), 4'h0);
    expect_val(3'h3, {4'h0, 16'h0000, 16'hFFFF, 4'h7});
    mode_set(ext(mrdt_pkg::TRIM_EXIT), 4'h0);
    expect_val(3'h4, 40'h0);
    $display("test drive done");
    mode_set(ext(mrdt_pkg::TRIM_DEFAULT), 4'h0);
    mode_set(ext(mrdt_pkg::TRIM_EXIT), 4'h0);
    pu = 5'h08;
    pd = 5'h08;
    for (int c = 0; c < 11; c++) begin
      if (c != 3 && c != 7) begin
        adj(4'(c));
        pu = pu + c[0] - c[1];
        pd = pd + c[2] - c[3];
        expect_val(3'h2, {30'h0, pu, pd});
      end
    end
    mode_set(ext(mrdt_pkg::TRIM_DEFAULT), 4'h0);
    mode_set(ext(mrdt_pkg::TRIM_EXIT), 4'h0);
    for (int k = 1; k < 19; k++) begin
      adj((k < 18) ? 4'h1 : 4'h2);
      expect_val(3'h2, {30'h0, (k < 16) ? 5'(8 + k) : 5'h18, 5'h08});
    end
    $display("test trim done");
    finish_test();
  end
endmodule
